// ==== include/sa_flow_pkg.sv ====
package sa_flow_pkg;
    // ======================================================================
    // Register map (byte addresses)
    localparam logic [15:0] ACTION_BASE    = 16'h7000;
    localparam logic [15:0] ACTION_LAST    = 16'h70ff;
    localparam logic [15:0] ENABLE_LO_ADDR = 16'h6000;
    localparam logic [15:0] ENABLE_HI_ADDR = 16'h6004;
    localparam logic [15:0] CLEAR_LO_ADDR  = 16'h6008;
    localparam logic [15:0] CLEAR_HI_ADDR  = 16'h600c;
    localparam logic [15:0] SET_LO_ADDR    = 16'h6010;
    localparam logic [15:0] SET_HI_ADDR    = 16'h6014;
    localparam logic [15:0] OCCUPANCY_ADDR = 16'h6018;
    localparam logic [15:0] STAT_SA_BASE   = 16'h8000;
    localparam logic [15:0] STAT_VLAN_BASE = 16'hc000;
    localparam logic [15:0] STAT_GLOB_BASE = 16'hc400;
    localparam logic [15:0] STAT_END       = 16'hc7ff;
    localparam int          STAT_WIDTH     = 40;
    // ======================================================================
    // Sizes
    localparam int          ENTRY_COUNT    = 64;
    localparam int          CNT_WIDTH      = 6;
    // ======================================================================
    // Occupancy register fields
    localparam int          LOAD_DRAIN_BIT = 31;
    localparam int          OCC_LSB        = 8;
    localparam int          DRAIN_LSB      = 0;
    // ======================================================================
    // Action word fields
    localparam int          CONF_EN_BIT    = 31;
    localparam int          OFFSET_LSB     = 24;
    localparam int          CHECK_LSB      = 19;
    localparam int          SCB_BIT        = 20;
    localparam int          ES_BIT         = 19;
    localparam int          SCI_BIT        = 18;
    localparam int          IN_USE_BIT     = 17;
    localparam int          PROT_BIT       = 16;
    localparam int          DISCARD_LSB    = 6;
    localparam int          NONRES_BIT     = 4;
    localparam int          DEST_LSB       = 2;
    localparam int          CLASS_LSB      = 0;
    localparam logic [31:0] INGRESS_MASK   = 32'h7f1b00df;
    localparam logic [31:0] EGRESS_MASK    = 32'hff1f00df;
    localparam logic [31:0] ACTION_RESET   = 32'h00000000;
    localparam logic [6:0]  OFFSET_MAX     = 7'h40;
    // ======================================================================
    // Encodings
    localparam logic [1:0]  CLASS_PASS     = 2'h0;
    localparam logic [1:0]  CLASS_DISCARD  = 2'h1;
    localparam logic [1:0]  CLASS_INGRESS  = 2'h2;
    localparam logic [1:0]  CLASS_EGRESS   = 2'h3;
    localparam logic [1:0]  DISC_NONE      = 2'h3;
    localparam logic [1:0]  DEST_RESERVED  = 2'h1;
endpackage

// ==== core/sa_count_tracker.sv ====
`timescale 1ns/1ps
`default_nettype none
module sa_count_tracker
    import sa_flow_pkg::*;
(
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // Events
    input  wire logic                 pkt_enter,
    input  wire logic                 pkt_done,
    input  wire logic                 drain_load,
    // Counts
    output logic     [CNT_WIDTH-1:0]  occupancy,
    output logic     [CNT_WIDTH-1:0]  drain
);
    logic [CNT_WIDTH-1:0] next_occupancy;
    logic [CNT_WIDTH-1:0] next_drain;
    logic [CNT_WIDTH-1:0] occ_after_done;

    always_comb begin
        next_occupancy = occupancy;
        if (pkt_enter && !pkt_done) begin
            next_occupancy = occupancy + 6'h01;
        end else if (pkt_done && !pkt_enter && occupancy != 6'h00) begin
            next_occupancy = occupancy - 6'h01;
        end
        // Completion in the load cycle would otherwise stay counted in drain
        occ_after_done = (pkt_done && occupancy != 6'h00) ? occupancy - 6'h01 : occupancy;
        next_drain = drain;
        if (drain_load) begin
            next_drain = occ_after_done;
        end else if (pkt_done && drain != 6'h00) begin
            next_drain = drain - 6'h01;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            occupancy <= 6'h00;
            drain     <= 6'h00;
        end else begin
            occupancy <= next_occupancy;
            drain     <= next_drain;
        end
    end

    chk_drain_floor: assert property (@(posedge ref_clk) disable iff (rst)
        (drain == 6'h00 && !drain_load) |=> drain == 6'h00)
        else $error("drain counter went below zero");
    chk_occ_balance: assert property (@(posedge ref_clk) disable iff (rst)
        (pkt_enter && pkt_done) |=> occupancy == $past(occupancy))
        else $error("occupancy moved on balanced cycle");
    chk_occ_inc: assert property (@(posedge ref_clk) disable iff (rst)
        (pkt_enter && !pkt_done) |=> occupancy == $past(occupancy) + 6'h01)
        else $error("occupancy did not increment");
endmodule
`default_nettype wire

// ==== core/sa_flow_control.sv ====
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module sa_flow_control
    import sa_flow_pkg::*;
#(
    parameter bit EGRESS      = 1'b0,
    parameter bit EGRESS_ONLY = 1'b0
)(
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // Register port
    input  wire logic [15:0]          reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [31:0]          reg_rdata,
    // Pipeline events
    input  wire logic                 pkt_enter,
    input  wire logic                 pkt_done,
    input  wire logic                 global_bypass,
    // Lookup
    input  wire logic                 lookup_valid,
    input  wire logic [5:0]           lookup_index,
    input  wire logic                 lookup_from_reserved,
    // Decoded action
    output logic                      act_valid,
    output logic      [1:0]           act_class,
    output logic      [1:0]           act_dest,
    output logic      [1:0]           act_discard,
    output logic                      act_do_discard,
    output logic      [6:0]           act_offset,
    output logic      [1:0]           act_check,
    output logic                      act_replay,
    output logic                      act_conf,
    output logic                      act_scb,
    output logic                      end_station_flag,
    output logic                      act_sci,
    output logic                      act_protect,
    output logic                      key_slot_active,
    // Entry state
    output logic      [63:0]          entry_enable,
    output logic                      stat_sel
);
    // ======================================================================
    // Storage
    // One array per instance; ingress and egress share offsets
    logic [31:0]          action_mem [ENTRY_COUNT];
    logic [63:0]          next_entry_enable;
    logic [31:0]          next_rdata;
    logic                 next_stat_sel;
    logic                 drain_load;
    logic [CNT_WIDTH-1:0] occupancy;
    logic [CNT_WIDTH-1:0] drain;
    logic                 wr_action;
    logic [5:0]           wr_index;
    logic [31:0]          word_mask;
    logic [31:0]          wr_word;
    logic [31:0]          lk;
    logic [1:0]           eff_class;

    // ======================================================================
    // Write decode
    always_comb begin
        wr_action = reg_wr && reg_addr >= ACTION_BASE && reg_addr <= ACTION_LAST
                    && reg_addr[1:0] == 2'h0;
        wr_index  = reg_addr[7:2];
        word_mask = EGRESS ? EGRESS_MASK : INGRESS_MASK;
        if (EGRESS_ONLY) begin
            word_mask[NONRES_BIT] = 1'b0;
        end
        wr_word = reg_wdata & word_mask;
        // Out-of-range offsets are kept as written; software owns that limit
    end

    always_ff @(posedge ref_clk) begin
        if (wr_action) begin
            action_mem[wr_index] <= wr_word;
        end
    end

    // ======================================================================
    // Entry enables
    always_comb begin
        next_entry_enable = entry_enable;
        if (reg_wr) begin
            unique case (reg_addr)
                ENABLE_LO_ADDR: next_entry_enable[31:0]  = reg_wdata;
                ENABLE_HI_ADDR: next_entry_enable[63:32] = reg_wdata;
                SET_LO_ADDR:    next_entry_enable[31:0]  = entry_enable[31:0] | reg_wdata;
                SET_HI_ADDR:    next_entry_enable[63:32] = entry_enable[63:32] | reg_wdata;
                CLEAR_LO_ADDR:  next_entry_enable[31:0]  = entry_enable[31:0] & ~reg_wdata;
                CLEAR_HI_ADDR:  next_entry_enable[63:32] = entry_enable[63:32] & ~reg_wdata;
                default:        next_entry_enable = entry_enable;
            endcase
        end
        drain_load = |(entry_enable & ~next_entry_enable);
        if (reg_wr && reg_addr == OCCUPANCY_ADDR && reg_wdata[LOAD_DRAIN_BIT]) begin
            drain_load = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            entry_enable <= 64'h0;
        end else begin
            entry_enable <= next_entry_enable;
        end
    end

    sa_count_tracker u_tracker (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .pkt_enter  (pkt_enter),
        .pkt_done   (pkt_done),
        .drain_load (drain_load),
        .occupancy  (occupancy),
        .drain      (drain)
    );

    // ======================================================================
    // Read path
    always_comb begin
        next_rdata    = 32'h0;
        next_stat_sel = 1'b0;
        if (reg_rd) begin
            if (reg_addr >= ACTION_BASE && reg_addr <= ACTION_LAST) begin
                next_rdata = action_mem[reg_addr[7:2]];
            end else if (reg_addr >= STAT_SA_BASE && reg_addr <= STAT_END) begin
                // Counter memory lives elsewhere; flag the region for it
                next_stat_sel = 1'b1;
            end else begin
                unique case (reg_addr)
                    ENABLE_LO_ADDR: next_rdata = entry_enable[31:0];
                    ENABLE_HI_ADDR: next_rdata = entry_enable[63:32];
                    OCCUPANCY_ADDR: next_rdata = {18'h0, occupancy, 2'h0, drain};
                    default:        next_rdata = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0;
            stat_sel  <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            stat_sel  <= next_stat_sel;
        end
    end

    // ======================================================================
    // Action decode
    always_comb begin
        lk        = action_mem[lookup_index];
        // Stored class untouched; only the decode is overruled
        eff_class = global_bypass ? CLASS_PASS : lk[CLASS_LSB +: 2];
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            act_valid        <= 1'b0;
            act_class        <= CLASS_PASS;
            act_dest         <= 2'h0;
            act_discard      <= 2'h0;
            act_do_discard   <= 1'b0;
            act_offset       <= 7'h0;
            act_check        <= 2'h0;
            act_replay       <= 1'b0;
            act_conf         <= 1'b0;
            act_scb          <= 1'b0;
            end_station_flag <= 1'b0;
            act_sci          <= 1'b0;
            act_protect      <= 1'b0;
            key_slot_active  <= 1'b0;
        end else begin
            act_valid        <= lookup_valid;
            act_class        <= eff_class;
            act_dest         <= lk[DEST_LSB +: 2];
            act_discard      <= lk[DISCARD_LSB +: 2];
            act_do_discard   <= lookup_valid && lk[DISCARD_LSB +: 2] != DISC_NONE
                                && (eff_class == CLASS_DISCARD
                                    || (lk[NONRES_BIT] && !lookup_from_reserved));
            act_offset       <= lk[OFFSET_LSB +: 7];
            act_check        <= (!EGRESS && eff_class == CLASS_INGRESS) ? lk[CHECK_LSB +: 2] : 2'h0;
            act_replay       <= !EGRESS && eff_class == CLASS_INGRESS && lk[PROT_BIT];
            act_conf         <= EGRESS && eff_class == CLASS_EGRESS && lk[CONF_EN_BIT];
            act_scb          <= EGRESS && eff_class == CLASS_EGRESS && lk[SCB_BIT];
            end_station_flag <= EGRESS && eff_class == CLASS_EGRESS && lk[ES_BIT];
            act_sci          <= EGRESS && eff_class == CLASS_EGRESS && lk[SCI_BIT];
            act_protect      <= EGRESS && eff_class == CLASS_EGRESS && lk[PROT_BIT];
            key_slot_active  <= lk[IN_USE_BIT];
        end
    end

    // ======================================================================
    // Checks
    chk_bypass_class: assert property (@(posedge ref_clk) disable iff (rst)
        global_bypass |=> act_class == CLASS_PASS)
        else $error("bypass not forced");
    chk_clear_load: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_wr && reg_addr == CLEAR_LO_ADDR && |(reg_wdata & entry_enable[31:0])) |-> drain_load)
        else $error("clear did not load drain");
    chk_load_drain: assert property (@(posedge ref_clk) disable iff (rst)
        (drain_load && !pkt_done) |=> drain == $past(occupancy))
        else $error("drain not loaded from occupancy");
    chk_replay_gate: assert property (@(posedge ref_clk) disable iff (rst)
        (eff_class != CLASS_INGRESS) |=> !act_replay)
        else $error("replay outside ingress");
    chk_prot_gate: assert property (@(posedge ref_clk) disable iff (rst)
        (eff_class != CLASS_EGRESS) |=> !act_protect && !act_conf)
        else $error("protect outside egress");
    chk_read_occ: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_rd && reg_addr == OCCUPANCY_ADDR) |=> reg_rdata[13:8] == $past(occupancy))
        else $error("occupancy read wrong");
endmodule
`default_nettype wire

// ==== test/sa_flow_control_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module sa_flow_control_tb_top
    import sa_flow_pkg::*;
;
    // ========================================
    // Signals
    typedef struct packed {logic care; logic stat; logic [31:0] data;} rd_note_t;
    logic        ref_clk, rst, reg_wr, reg_rd, pkt_enter, pkt_done, global_bypass;
    logic        lookup_valid, lookup_from_reserved, act_valid, act_do_discard, act_replay;
    logic        act_conf, act_scb, end_station_flag, act_sci, act_protect, key_slot_active;
    logic        stat_sel, rd_seen;
    logic [1:0]  act_class, act_dest, act_discard, act_check;
    logic [6:0]  act_offset;
    logic [5:0]  lookup_index;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, lfsr, w;
    logic [63:0] entry_enable;
    rd_note_t    note;
    rd_note_t    rd_q[$];
    logic [22:0] act_q[$];
    logic [22:0] act_e_q[$];
    wire logic [22:0] e_act;
    logic        e_valid;
    int          mismatches, compares;
    logic [15:0] stat_addr [4] = '{STAT_SA_BASE, STAT_VLAN_BASE, STAT_GLOB_BASE, STAT_END};
    logic [5:0]  word_idx [6] = '{6'h00, 6'h01, 6'h1f, 6'h20, 6'h3e, 6'h3f};

    sa_flow_control #(.EGRESS(1'b0), .EGRESS_ONLY(1'b0)) DUT (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pkt_enter(pkt_enter),
        .pkt_done(pkt_done), .global_bypass(global_bypass), .lookup_valid(lookup_valid),
        .lookup_index(lookup_index), .lookup_from_reserved(lookup_from_reserved),
        .act_valid(act_valid), .act_class(act_class), .act_dest(act_dest),
        .act_discard(act_discard), .act_do_discard(act_do_discard), .act_offset(act_offset),
        .act_check(act_check), .act_replay(act_replay), .act_conf(act_conf), .act_scb(act_scb),
        .end_station_flag(end_station_flag), .act_sci(act_sci), .act_protect(act_protect),
        .key_slot_active(key_slot_active), .entry_enable(entry_enable), .stat_sel(stat_sel));

    // Egress layout twin on the same stimulus
    sa_flow_control #(.EGRESS(1'b1), .EGRESS_ONLY(1'b0)) DUT_EG (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .pkt_enter(pkt_enter),
        .pkt_done(pkt_done), .global_bypass(global_bypass), .lookup_valid(lookup_valid),
        .lookup_index(lookup_index), .lookup_from_reserved(lookup_from_reserved),
        .act_valid(e_valid), .act_class(e_act[22:21]), .act_dest(e_act[20:19]),
        .act_discard(e_act[18:17]), .act_do_discard(e_act[16]), .act_offset(e_act[15:9]),
        .act_check(e_act[8:7]), .act_replay(e_act[6]), .act_conf(e_act[5]), .act_scb(e_act[4]),
        .end_station_flag(e_act[3]), .act_sci(e_act[2]), .act_protect(e_act[1]),
        .key_slot_active(e_act[0]), .entry_enable(), .stat_sel());

    // ========================================
    // Helpers
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Ingress instance: egress-only outputs stay low
    function automatic logic [22:0] act_expect(input logic [31:0] v, input logic byp, input logic res);
        logic [1:0] cls;
        logic       drop;
        cls = byp ? CLASS_PASS : v[1:0];
        drop = (v[7:6] != DISC_NONE) && (cls == CLASS_DISCARD || (v[4] && !res));
        return {cls, v[3:2], v[7:6], drop, v[30:24], (cls == CLASS_INGRESS) ? v[20:19] : 2'h0,
                (cls == CLASS_INGRESS) & v[16], 5'h00, v[17]};
    endfunction

    // Egress instance: ingress-only outputs stay low
    function automatic logic [22:0] act_expect_e(input logic [31:0] v, input logic byp, input logic res);
        logic [1:0] cls;
        logic       drop;
        logic       e;
        cls = byp ? CLASS_PASS : v[1:0];
        drop = (v[7:6] != DISC_NONE) && (cls == CLASS_DISCARD || (v[4] && !res));
        e = (cls == CLASS_EGRESS);
        return {cls, v[3:2], v[7:6], drop, v[30:24], 2'h0, 1'b0,
                e & v[31], e & v[20], e & v[19], e & v[18], e & v[16], v[17]};
    endfunction

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run;
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [15:0] a, input logic [31:0] d, input logic done);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        pkt_done <= done;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        pkt_done <= 1'b0;
    endtask

    task automatic reg_read(input logic [15:0] a, input logic stat, input logic care, input logic [31:0] d);
        rd_q.push_back({care, stat, d});
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic pkts(input logic ent, input logic done, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            pkt_enter <= ent;
            pkt_done <= done;
        end
        @(posedge ref_clk);
        pkt_enter <= 1'b0;
        pkt_done <= 1'b0;
    endtask

    task automatic lookup(input logic [5:0] idx, input logic byp, input logic res, input logic [31:0] v);
        act_q.push_back(act_expect(v, byp, res));
        act_e_q.push_back(act_expect_e(v, byp, res));
        @(posedge ref_clk);
        lookup_valid <= 1'b1;
        lookup_index <= idx;
        lookup_from_reserved <= res;
        global_bypass <= byp;
        @(posedge ref_clk);
        lookup_valid <= 1'b0;
    endtask

    // ========================================
    // Monitor: results come off the queues oldest first
    always @(posedge ref_clk) rd_seen <= reg_rd;

    always @(negedge ref_clk) begin
        if (rd_seen === 1'b1) begin
            note = rd_q.pop_front();
            if (note.care) check("reg_rdata", {32'h0, reg_rdata}, {32'h0, note.data});
            check("stat_sel", {63'h0, stat_sel}, {63'h0, note.stat});
        end
        if (act_valid === 1'b1) begin
            check("act", {41'h0, act_class, act_dest, act_discard, act_do_discard, act_offset, act_check,
                  act_replay, act_conf, act_scb, end_station_flag, act_sci, act_protect, key_slot_active},
                  {41'h0, act_q.pop_front()});
        end
        if (e_valid === 1'b1) begin
            check("act_eg", {41'h0, e_act}, {41'h0, act_e_q.pop_front()});
        end
    end

    // ========================================
    // Clock, watchdog, sequence
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Whole sequence needs about 200 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        complete_run();
    end

    initial begin
        rst = 1'b1;
        rd_seen = 1'b0;
        {reg_wr, reg_rd, pkt_enter, pkt_done, global_bypass, lookup_valid, lookup_from_reserved} = 7'h00;
        reg_addr = 16'h0000;
        reg_wdata = 32'h00000000;
        lookup_index = 6'h00;
        lfsr = 32'h00000037;
        repeat (16) @(posedge ref_clk);
        check("entry_enable", entry_enable, 64'h0);
        rst <= 1'b0;
        reg_read(OCCUPANCY_ADDR, 1'b0, 1'b1, 32'h0);
        foreach (stat_addr[k]) reg_read(stat_addr[k], 1'b1, 1'b0, 32'h0);
        reg_read(16'h5000, 1'b0, 1'b1, 32'h0);
        reg_read(16'h7100, 1'b0, 1'b1, 32'h0);
        reg_read(16'hc800, 1'b0, 1'b1, 32'h0);
        pkts(1'b1, 1'b0, 5);
        pkts(1'b1, 1'b1, 3);
        pkts(1'b0, 1'b1, 2);
        reg_read(OCCUPANCY_ADDR, 1'b0, 1'b1, 32'h00000300);
        reg_write(OCCUPANCY_ADDR, 32'h7fffffff, 1'b0);
        reg_read(OCCUPANCY_ADDR, 1'b0, 1'b1, 32'h00000300);
        reg_write(OCCUPANCY_ADDR, 32'h80000000, 1'b0);
        reg_read(OCCUPANCY_ADDR, 1'b0, 1'b1, 32'h00000303);
        reg_write(OCCUPANCY_ADDR, 32'h80000000, 1'b1);
        reg_read(OCCUPANCY_ADDR, 1'b0, 1'b1, 32'h00000202);
        pkts(1'b1, 1'b1, 5);
        reg_read(OCCUPANCY_ADDR, 1'b0, 1'b1, 32'h00000200);
        reg_write(SET_LO_ADDR, 32'hffffffff, 1'b0);
        reg_write(SET_HI_ADDR, 32'h00000101, 1'b0);
        reg_write(CLEAR_LO_ADDR, 32'h00000000, 1'b0);
        reg_read(ENABLE_LO_ADDR, 1'b0, 1'b1, 32'hffffffff);
        reg_read(OCCUPANCY_ADDR, 1'b0, 1'b1, 32'h00000200);
        pkts(1'b1, 1'b0, 3);
        reg_write(CLEAR_HI_ADDR, 32'h00000001, 1'b0);
        reg_read(ENABLE_HI_ADDR, 1'b0, 1'b1, 32'h00000100);
        reg_read(OCCUPANCY_ADDR, 1'b0, 1'b1, 32'h00000505);
        pkts(1'b0, 1'b1, 2);
        pkts(1'b1, 1'b0, 2);
        reg_write(ENABLE_LO_ADDR, 32'hfffffffe, 1'b0);
        @(negedge ref_clk);
        check("entry_enable", entry_enable, 64'h00000100_fffffffe);
        reg_read(OCCUPANCY_ADDR, 1'b0, 1'b1, 32'h00000505);
        pkts(1'b0, 1'b1, 5);
        reg_read(OCCUPANCY_ADDR, 1'b0, 1'b1, 32'h00000000);
        foreach (word_idx[k]) begin
            lfsr = next_rand(lfsr);
            reg_write(ACTION_BASE + {8'h00, word_idx[k], 2'b00}, lfsr, 1'b0);
            reg_read(ACTION_BASE + {8'h00, word_idx[k], 2'b00}, 1'b0, 1'b1, lfsr & INGRESS_MASK);
        end
        reg_write(ACTION_BASE + 16'h0008, 32'h40000000, 1'b0);
        reg_read(ACTION_BASE + 16'h0008, 1'b0, 1'b1, 32'h40000000);
        for (int i = 0; i < 16; i++) begin
            lfsr = next_rand(lfsr);
            w = lfsr & EGRESS_MASK;
            w[1:0] = i[1:0];
            if (i[3]) w[7:6] = DISC_NONE;
            reg_write(ACTION_BASE + 16'((i * 4 + 3) * 4), w, 1'b0);
            lookup(6'(i * 4 + 3), i[3], i[2], w);
        end
        repeat (4) @(posedge ref_clk);
        complete_run();
    end
endmodule
`default_nettype wire
